/* hw/sac_top.sv */
// Register access over Wishbone and the register offsets were left to the implementer.
`include "sac_consts.svh"

// access control block: wishbone registers, access checker, mode latch
module sac_top
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// wishbone slave
	input  wire logic        i_wb_cyc,
	input  wire logic        i_wb_stb,
	input  wire logic        i_wb_we,
	input  wire logic [7:0]  i_wb_adr,
	input  wire logic [3:0]  i_wb_sel,
	input  wire logic [31:0] i_wb_dat,
	output logic [31:0]      o_wb_dat,
	output logic             o_wb_ack,
	// processor access being checked
	input  wire logic        i_acc_valid,
	input  wire logic [15:0] i_acc_addr,
	input  wire logic        i_acc_write,
	input  wire logic        i_acc_fetch,
	input  wire logic        i_priv_entry,
	// non-volatile storage side
	input  wire logic        i_nv_normal,
	input  wire logic [31:0] i_trace_data,
	output logic             o_nv_trace_wr,
	output logic [31:0]      o_nv_trace_wdata,
	output logic             o_nv_normal_set,
	// interrupts and status
	output logic             o_fast_nonmaskable_irq,
	output logic             o_irq,
	output logic             o_acc_deny,
	output logic             o_normal_mode,
	output logic             o_user_mode
);
	// bus state
	logic        ack_reg,   ack_next;
	logic [31:0] rdata_reg, rdata_next;
	// security state
	logic        sec_we_reg, sec_we_next;
	logic        user_reg,   user_next;
	logic        lock_reg,   lock_next;
	logic [7:0]  cnt_reg,    cnt_next;
	logic        normal_reg, normal_next;
	logic        nvset_reg,  nvset_next;
	logic [7:0]  mac_reg,    mac_next;
	logic [15:0] base_reg  [4];
	logic [15:0] base_next [4];
	logic [15:0] limit_reg  [4];
	logic [15:0] limit_next [4];
	logic [3:0]  attr_reg  [4];
	logic [3:0]  attr_next [4];
	// events and interrupts
	logic [3:0]  status_reg, status_next;
	logic [3:0]  mask_reg,   mask_next;
	logic        irq_reg,    irq_next;
	logic        fiq_reg,    fiq_next;
	logic        deny_reg,   deny_next;
	logic [15:0] viol_reg,   viol_next;
	// trace write port
	logic        twr_reg,    twr_next;
	logic [31:0] twd_reg,    twd_next;

	logic        req;
	logic        wr;
	logic        sec_ok;
	logic        auth;
	logic        permit;
	logic [3:0]  ev;
	logic [31:0] wdat;
	logic [63:0] bases;
	logic [63:0] limits;
	logic [15:0] attrs;

	// register index of a region slot, 8 when not a region
	function automatic logic [3:0] rgn_slot(input logic [7:0] adr);
		if (adr >= `SAC_OFS_RGN_BASE && adr <= `SAC_OFS_RGN_LAST)
			rgn_slot = {1'b0, adr[4:2]};
		else
			rgn_slot = 4'h8;
	endfunction

	// registers guarded by the security write enable
	function automatic logic is_sec(input logic [7:0] adr);
		is_sec = (adr == `SAC_OFS_MAC) || (rgn_slot(adr) != 4'h8);
	endfunction

	// byte-lane merge of write data into an old value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			merge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
	endfunction

	// at most one request every two cycles; ack blocks req in its own cycle, so a held strobe repeats only after ack drops
	assign req    = i_wb_cyc && i_wb_stb && !ack_reg;
	assign wr     = req && i_wb_we;
	assign wdat   = merge(32'h0, i_wb_dat, i_wb_sel);
	assign sec_ok = !lock_reg && (!user_reg || sec_we_reg);

	// region settings flattened for the checker
	genvar g;
	generate
		for (g = 0; g < sac_pkg::SAC_REGIONS; g++)
		begin : g_pack
			assign bases[16*g +: 16]  = base_reg[g];
			assign limits[16*g +: 16] = limit_reg[g];
			assign attrs[4*g +: 4]    = attr_reg[g];
		end
	endgenerate

	sac_region_check u_rgn
	(
		.i_addr   (i_acc_addr),
		.i_write  (i_acc_write),
		.i_fetch  (i_acc_fetch),
		.i_user   (user_reg),
		.i_bases  (bases),
		.i_limits (limits),
		.i_attrs  (attrs),
		.o_permit (permit)
	);

	sac_pw_check u_pw
	(
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_try    (wr && i_wb_adr == `SAC_OFS_PASSWORD),
		.i_word   (i_wb_dat),
		.i_normal (normal_reg),
		.o_auth   (auth)
	);

	// access events; eeprom fetches follow the exec path only
	always_comb
	begin
		ev = 4'h0;
		if (i_acc_valid)
		begin
			if (i_acc_addr >= `SAC_ADDR_LIMIT)
				ev[`SAC_EV_INVALID] = 1'b1;
			else if (i_acc_fetch && i_acc_addr >= `SAC_EE_FIRST
				&& i_acc_addr <= `SAC_EE_LAST)
				ev[`SAC_EV_EXEC] = !mac_reg[`SAC_MAC_EXEC_EN]
					|| !permit;
			else if (mac_reg[`SAC_MAC_CHECK_EN])
				ev[`SAC_EV_RIGHTS] = !permit;
		end
		ev[`SAC_EV_REFUSED] = wr && is_sec(i_wb_adr) && !sec_ok;
	end

	// security, mode and region state
	always_comb
	begin
		sec_we_next = sec_we_reg;
		user_next   = user_reg;
		mac_next    = mac_reg;
		cnt_next    = cnt_reg;
		lock_next   = lock_reg;
		base_next   = base_reg;
		limit_next  = limit_reg;
		attr_next   = attr_reg;
		// window counts once per reset and then freezes
		if (cnt_reg != `SAC_WE_WINDOW_CYC)
			cnt_next = cnt_reg + 8'h01;
		if (wr && i_wb_adr == `SAC_OFS_CTRL && i_wb_sel[0])
		begin
			if (cnt_reg != `SAC_WE_WINDOW_CYC && !lock_reg)
				sec_we_next = i_wb_dat[`SAC_CTRL_SEC_WE];
			// dropping to user is allowed unless i_priv_entry comes in the same cycle, climbing back is not
			if (i_wb_dat[`SAC_CTRL_USER] || !user_reg)
				user_next = i_wb_dat[`SAC_CTRL_USER];
		end
		if (i_priv_entry)
			user_next = 1'b0;
		// judged after this cycle's write so a last-cycle enable still counts
		if (cnt_next == `SAC_WE_WINDOW_CYC && !sec_we_next)
			lock_next = 1'b1;
		if (wr && sec_ok && i_wb_adr == `SAC_OFS_MAC)
			mac_next = 8'(merge({24'h0, mac_reg}, wdat, i_wb_sel));
		if (wr && sec_ok && rgn_slot(i_wb_adr) != 4'h8)
		begin
			if (!i_wb_adr[2])
				base_next[i_wb_adr[4:3]] = wdat[15:0];
			else
			begin
				limit_next[i_wb_adr[4:3]] = wdat[15:0];
				attr_next[i_wb_adr[4:3]]  = wdat[19:16];
			end
		end
	end

	// test to normal switch, trace writes, events and bus answer
	always_comb
	begin
		normal_next = normal_reg || i_nv_normal;
		nvset_next  = 1'b0;
		twr_next    = 1'b0;
		twd_next    = twd_reg;
		mask_next   = mask_reg;
		viol_next   = viol_reg;
		status_next = status_reg;
		ack_next    = req;
		rdata_next  = 32'h0;
		if (wr && i_wb_adr == `SAC_OFS_SWITCH && i_wb_dat == `SAC_SWITCH_KEY
			&& !normal_reg)
		begin
			normal_next = 1'b1;
			nvset_next  = 1'b1;
		end
		if (wr && i_wb_adr == `SAC_OFS_TRACE && !normal_reg && auth)
		begin
			twr_next = 1'b1;
			twd_next = i_wb_dat;
		end
		if (wr && i_wb_adr == `SAC_OFS_MASK)
			mask_next = wdat[3:0];
		// write-one-to-clear, a new event in the same cycle wins
		if (wr && i_wb_adr == `SAC_OFS_STATUS)
			status_next = status_reg & ~wdat[3:0];
		status_next = status_next | ev;
		if (|ev[2:0])
			viol_next = i_acc_addr;
		if (req && !i_wb_we)
		begin
			if (i_wb_adr == `SAC_OFS_CTRL)
				rdata_next = {21'h0, auth, normal_reg, lock_reg, 6'h0,
					user_reg, sec_we_reg};
			else if (i_wb_adr == `SAC_OFS_MAC)
				rdata_next = {24'h0, mac_reg};
			else if (i_wb_adr == `SAC_OFS_STATUS)
				rdata_next = {28'h0, status_reg};
			else if (i_wb_adr == `SAC_OFS_MASK)
				rdata_next = {28'h0, mask_reg};
			else if (i_wb_adr == `SAC_OFS_TRACE)
				rdata_next = i_trace_data;
			else if (i_wb_adr == `SAC_OFS_VIOL_ADDR)
				rdata_next = {16'h0, viol_reg};
			else if (rgn_slot(i_wb_adr) != 4'h8)
				rdata_next = i_wb_adr[2] ?
					{12'h0, attr_reg[i_wb_adr[4:3]],
					limit_reg[i_wb_adr[4:3]]} :
					{16'h0, base_reg[i_wb_adr[4:3]]};
		end
		// the fast request cannot be masked; only the ordinary request can, for all four events
		fiq_next  = |(status_next & `SAC_EV_NMI_MASK);
		irq_next  = |(status_next & mask_next);
		deny_next = |ev[2:0];
	end

	// all defaults loaded at power-on reset
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ack_reg    <= 1'b0;
			rdata_reg  <= 32'h0;
			sec_we_reg <= 1'b0;
			user_reg   <= 1'b0;
			lock_reg   <= 1'b0;
			cnt_reg    <= 8'h00;
			normal_reg <= 1'b0;
			nvset_reg  <= 1'b0;
			mac_reg    <= `SAC_MAC_RESET;
			status_reg <= 4'h0;
			mask_reg   <= 4'h0;
			irq_reg    <= 1'b0;
			fiq_reg    <= 1'b0;
			deny_reg   <= 1'b0;
			viol_reg   <= 16'h0;
			twr_reg    <= 1'b0;
			twd_reg    <= 32'h0;
			for (int i = 0; i < 4; i++)
			begin
				base_reg[i]  <= 16'h0;
				limit_reg[i] <= 16'h0;
				attr_reg[i]  <= 4'h0;
			end
		end
		else
		begin
			ack_reg    <= ack_next;
			rdata_reg  <= rdata_next;
			sec_we_reg <= sec_we_next;
			user_reg   <= user_next;
			lock_reg   <= lock_next;
			cnt_reg    <= cnt_next;
			normal_reg <= normal_next;
			nvset_reg  <= nvset_next;
			mac_reg    <= mac_next;
			status_reg <= status_next;
			mask_reg   <= mask_next;
			irq_reg    <= irq_next;
			fiq_reg    <= fiq_next;
			deny_reg   <= deny_next;
			viol_reg   <= viol_next;
			twr_reg    <= twr_next;
			twd_reg    <= twd_next;
			base_reg   <= base_next;
			limit_reg  <= limit_next;
			attr_reg   <= attr_next;
		end
	end

	// outputs straight from flip-flops
	assign o_wb_ack               = ack_reg;
	assign o_wb_dat               = rdata_reg;
	assign o_nv_trace_wr          = twr_reg;
	assign o_nv_trace_wdata       = twd_reg;
	assign o_nv_normal_set        = nvset_reg;
	assign o_fast_nonmaskable_irq = fiq_reg;
	assign o_irq                  = irq_reg;
	assign o_acc_deny             = deny_reg;
	assign o_normal_mode          = normal_reg;
	assign o_user_mode            = user_reg;
endmodule

/* hw/sac_consts.svh */
`ifndef SAC_CONSTS_SVH
`define SAC_CONSTS_SVH

// register byte offsets
`define SAC_OFS_CTRL      8'h00
`define SAC_OFS_MAC       8'h04
`define SAC_OFS_STATUS    8'h08
`define SAC_OFS_MASK      8'h0c
`define SAC_OFS_SWITCH    8'h10
`define SAC_OFS_PASSWORD  8'h14
`define SAC_OFS_TRACE     8'h18
`define SAC_OFS_VIOL_ADDR 8'h1c
`define SAC_OFS_RGN_BASE  8'h20
`define SAC_OFS_RGN_LAST  8'h3c

// control register fields
`define SAC_CTRL_SEC_WE   0
`define SAC_CTRL_USER     1
`define SAC_CTRL_LOCK     8
`define SAC_CTRL_NORMAL   9
`define SAC_CTRL_AUTH     10

// memory access config fields
`define SAC_MAC_CHECK_EN  0
`define SAC_MAC_EXEC_EN   1
`define SAC_MAC_RESET     8'h00

// status / mask bits
`define SAC_EV_INVALID    0
`define SAC_EV_RIGHTS     1
`define SAC_EV_EXEC       2
`define SAC_EV_REFUSED    3
`define SAC_EV_NMI_MASK   4'h7

// region attribute bits
`define SAC_ATTR_READ     0
`define SAC_ATTR_WRITE    1
`define SAC_ATTR_EXEC     2
`define SAC_ATTR_USER     3

// memory map of the checked bus
`define SAC_ADDR_LIMIT    16'hf000
`define SAC_EE_FIRST      16'h8000
`define SAC_EE_LAST       16'hbfff

// timing and keys
`define SAC_WE_WINDOW_CYC 8'h80
`define SAC_SWITCH_KEY    32'h5a5aa5a5
`define SAC_TEST_PASSWORD 32'h13572468
`endif

/* hw/sac_pkg.sv */
package sac_pkg;
	typedef logic [15:0] sac_addr_t;
	typedef logic [3:0]  sac_attr_t;
	typedef logic [31:0] sac_word_t;
	localparam int SAC_REGIONS = 4;
endpackage

/* hw/sac_region_check.sv */
`include "sac_consts.svh"

// region rights lookup, purely combinational
module sac_region_check
(
	// access under test
	input  wire logic [15:0] i_addr,
	input  wire logic        i_write,
	input  wire logic        i_fetch,
	input  wire logic        i_user,
	// region settings, region k in slice k
	input  wire logic [63:0] i_bases,
	input  wire logic [63:0] i_limits,
	input  wire logic [15:0] i_attrs,
	// result
	output logic             o_permit
);
	logic [3:0] hit;
	logic [3:0] ok;

	// one comparator set per region
	genvar k;
	generate
		for (k = 0; k < sac_pkg::SAC_REGIONS; k++)
		begin : g_rgn
			logic [3:0] a;
			assign a = i_attrs[4*k +: 4];
			assign hit[k] = (i_addr >= i_bases[16*k +: 16])
				&& (i_addr <= i_limits[16*k +: 16]);
			assign ok[k] = (i_fetch ? a[`SAC_ATTR_EXEC] :
				i_write ? a[`SAC_ATTR_WRITE] : a[`SAC_ATTR_READ])
				&& (a[`SAC_ATTR_USER] || !i_user);
		end
	endgenerate

	// outside every region only privileged code passes
	always_comb
	begin
		if (|hit)
			o_permit = |(hit & ok);
		else
			o_permit = !i_user;
	end
endmodule

/* hw/sac_pw_check.sv */
`include "sac_consts.svh"

// test-mode password gate
module sac_pw_check
(
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// password attempt
	input  wire logic        i_try,
	input  wire logic [31:0] i_word,
	input  wire logic        i_normal,
	// result
	output logic             o_auth
);
	logic auth_reg;
	logic auth_next;

	// a wrong try drops authentication; normal mode revokes it for good
	always_comb
	begin
		auth_next = auth_reg;
		if (i_normal)
			auth_next = 1'b0;
		else if (i_try)
			auth_next = (i_word == `SAC_TEST_PASSWORD);
	end

	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
			auth_reg <= 1'b0;
		else
			auth_reg <= auth_next;
	end

	assign o_auth = auth_reg;
endmodule

/* sim/sac_top_sva.sv */
module sac_top_sva
(
	// clock and reset
	input wire logic        i_clk,
	input wire logic        i_resetn,
	// register bus
	input wire logic        i_wb_cyc,
	input wire logic        i_wb_stb,
	input wire logic        i_wb_we,
	input wire logic [7:0]  i_wb_adr,
	input wire logic        o_wb_ack,
	// access check and modes
	input wire logic        i_acc_valid,
	input wire logic [15:0] i_acc_addr,
	input wire logic        o_acc_deny,
	input wire logic        o_fast_nonmaskable_irq,
	input wire logic        o_normal_mode,
	input wire logic        o_nv_normal_set,
	input wire logic        o_nv_trace_wr
);
	timeunit 1ns;
	timeprecision 1ns;

	logic st_wr;

	// a status write is the only legal way to drop the fast interrupt
	assign st_wr = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr == 8'h08;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_resetn);

	// bus answer, violation reporting and the one-way mode latch
	a_ack_single: assert property (
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
		else $error("ack is not a single pulse after the request");
	a_invalid_deny: assert property (
		i_acc_valid && i_acc_addr >= 16'hf000 |=> o_acc_deny)
		else $error("invalid address access not denied");
	a_deny_cause: assert property (
		o_acc_deny |-> $past(i_acc_valid))
		else $error("deny without a preceding access");
	a_deny_fiq: assert property (
		o_acc_deny |-> o_fast_nonmaskable_irq)
		else $error("deny without fast interrupt");
	a_fiq_holds: assert property (
		o_fast_nonmaskable_irq && !st_wr |=> o_fast_nonmaskable_irq)
		else $error("fast interrupt dropped without status clear");
	a_normal_sticky: assert property (
		o_normal_mode |=> o_normal_mode)
		else $error("normal mode left without reset");
	a_switch_normal: assert property (
		o_nv_normal_set |-> ##[0:2] o_normal_mode)
		else $error("switch pulse without normal mode");
	a_trace_test: assert property (
		o_nv_trace_wr |-> !o_normal_mode)
		else $error("trace written in normal mode");

	// main scenarios reached
	c_deny: cover property (o_acc_deny);
	c_normal: cover property ($rose(o_normal_mode));
	c_trace: cover property (o_nv_trace_wr);
endmodule

bind sac_top sac_top_sva u_sva (.*);

/* sim/sac_nv_model.sv */
// non-volatile store: keeps its state across every chip reset
module sac_nv_model
(
	// clock
	input  wire logic        i_clk,
	// requests from the block
	input  wire logic        i_trace_wr,
	input  wire logic [31:0] i_trace_wdata,
	input  wire logic        i_normal_set,
	// stored state
	output logic             o_normal,
	output logic [31:0]      o_trace
);
	timeunit 1ns;
	timeprecision 1ns;

	// stores any trace write: refusing them is the block's job, not ours
	initial
	begin
		o_normal = 1'b0;
		o_trace = 32'h0;
		forever
		begin
			@(posedge i_clk);
			if (i_normal_set)
				o_normal <= 1'b1;
			if (i_trace_wr)
				o_trace <= i_trace_wdata;
		end
	end
endmodule

/* sim/secure_access_control_test.sv */
module secure_access_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        i_clk, i_resetn, cyc, stb, we, ack, acc_v, acc_w, acc_f;
	logic        priv, nv_norm, tr_wr, norm_set, fast_nonmaskable_irq, irq, deny, nmode, umode;
	logic [7:0]  adr;
	logic [3:0]  sel, wsel;
	logic [15:0] acc_a;
	logic [31:0] dat, rdat, trace, q, tr_wdat;
	logic [7:0]  offs [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h1c, 8'h40};
	int          n_fail = 0;
	int          tests_run = 0;

	sac_top dut
	(
		.i_clk(i_clk), .i_resetn(i_resetn), .i_wb_cyc(cyc), .i_wb_stb(stb),
		.i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_acc_valid(acc_v),
		.i_acc_addr(acc_a), .i_acc_write(acc_w), .i_acc_fetch(acc_f),
		.i_priv_entry(priv), .i_nv_normal(nv_norm), .i_trace_data(trace),
		.o_nv_trace_wr(tr_wr), .o_nv_trace_wdata(tr_wdat),
		.o_nv_normal_set(norm_set), .o_fast_nonmaskable_irq(fast_nonmaskable_irq),
		.o_irq(irq), .o_acc_deny(deny), .o_normal_mode(nmode),
		.o_user_mode(umode)
	);

	sac_nv_model nv
	(
		.i_clk(i_clk), .i_trace_wr(tr_wr), .i_trace_wdata(tr_wdat),
		.i_normal_set(norm_set), .o_normal(nv_norm), .o_trace(trace)
	);

	// 10 MHz clock
	always #50 i_clk = ~i_clk;

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string s, input logic [31:0] e, g);
		tests_run++;
		if (g !== e)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask

	// classic single cycle; the request stands until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge i_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= wsel;
		dat <= d;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			n_fail++;
			report_and_stop();
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string s);
		wb(1'b0, a, 32'h0);
		chk(s, e, q);
	endtask

	// one checked access; deny is registered at the edge that takes it
	task automatic acc(input logic [15:0] a, input logic w, f, e);
		@(posedge i_clk);
		acc_v <= 1'b1;
		acc_a <= a;
		acc_w <= w;
		acc_f <= f;
		@(posedge i_clk);
		acc_v <= 1'b0;
		#1 chk("deny", 32'(e), 32'(deny));
	endtask

	initial
	begin
		i_clk = 0;
		i_resetn = 0;
		{cyc, stb, we, acc_v, acc_w, acc_f, priv} = '0;
		adr = 0;
		sel = 4'hf;
		wsel = 4'hf;
		dat = 0;
		acc_a = 0;
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		for (int i = 0; i < 6; i++)
			rd(offs[i], 32'h0, "reset value");
		wb(1, 8'h20, 32'h0);
		wb(1, 8'h24, 32'h00010fff);
		wb(1, 8'h04, 32'h1);
		acc(16'h0100, 0, 0, 0);
		acc(16'h0100, 1, 0, 1);
		rd(8'h08, 32'h2, "status");
		wb(1, 8'h08, 32'hf);
		wb(1, 8'h00, 32'h2);
		chk("user", 1, 32'(umode));
		acc(16'h0100, 0, 0, 1);
		wb(1, 8'h04, 32'h0);
		rd(8'h04, 32'h1, "mac");
		rd(8'h08, 32'ha, "status");
		wb(1, 8'h0c, 32'h8);
		repeat (2) @(posedge i_clk);
		chk("irq", 1, 32'(irq));
		wb(1, 8'h0c, 32'h0);
		repeat (2) @(posedge i_clk);
		chk("irq", 0, 32'(irq));
		acc(16'hf000, 0, 0, 1);
		chk("fiq", 1, 32'(fast_nonmaskable_irq));
		rd(8'h1c, 32'hf000, "viol addr");
		wb(1, 8'h08, 32'hf);
		rd(8'h08, 32'h0, "status");
		chk("fiq", 0, 32'(fast_nonmaskable_irq));
		acc(16'h8000, 0, 1, 1);
		rd(8'h08, 32'h4, "status");
		wb(1, 8'h08, 32'hf);
		repeat (130) @(posedge i_clk);
		priv <= 1'b1;
		@(posedge i_clk);
		priv <= 1'b0;
		rd(8'h00, 32'h100, "ctrl");
		wb(1, 8'h04, 32'h0);
		rd(8'h04, 32'h1, "mac");
		wb(1, 8'h18, 32'h1111);
		rd(8'h18, 32'h0, "trace");
		wb(1, 8'h14, 32'h1);
		rd(8'h00, 32'h100, "ctrl");
		wb(1, 8'h14, 32'h13572468);
		rd(8'h00, 32'h500, "ctrl");
		wb(1, 8'h18, 32'hc0ffee);
		rd(8'h18, 32'hc0ffee, "trace");
		wb(1, 8'h10, 32'h0);
		chk("normal", 0, 32'(nmode));
		wb(1, 8'h10, 32'h5a5aa5a5);
		repeat (3) @(posedge i_clk);
		chk("normal", 1, 32'(nmode));
		wb(1, 8'h18, 32'h1);
		rd(8'h18, 32'hc0ffee, "trace");
		@(posedge i_clk);
		i_resetn <= 1'b0;
		repeat (16) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_clk);
		chk("normal", 1, 32'(nmode));
		wb(1, 8'h14, 32'h13572468);
		rd(8'h00, 32'h200, "ctrl");
		wsel = 4'he;
		wb(1, 8'h00, 32'h3);
		wsel = 4'hf;
		rd(8'h00, 32'h200, "ctrl lane0 off");
		wb(1, 8'h00, 32'h3);
		rd(8'h00, 32'h203, "ctrl");
		wb(1, 8'h04, 32'h2);
		rd(8'h04, 32'h2, "mac user");
		rd(8'h08, 32'h0, "status");
		report_and_stop();
	end
endmodule
